// ==== hbfw_cfg.svh ====
// Behaviour
// - Write starts with 1110 while strobe low
// - Seven address nibbles, most significant first
// - Nonzero size nibble: drop cycle silently
// - Data byte low nibble then high
// - Host turnaround 1111, device takes bus
// - Device answers ready sync 0000
// - Device drives 1111, floats, host resumes
// - Strobe low mid-cycle terminates, await abort
// - Abort nibble 1111 returns to ready
// - Decode only low twenty address bits and bit 22
// - Address bit 22 selects core/registers
// - Boot protect low locks top block
// - Write protect low locks other blocks
// - Protection is pin low OR lock bit
// - Protect pins set and held before writes
// - Either reset pin resets the device
// - Reset floats the nibble outputs
// - Reset aborts running program or erase
// - Program: poll bit complemented, 1us settle
// - Erase: poll bit 0 then 1
// - Host rereads status twice on doubt
`ifndef HBFW_CFG_SVH
`define HBFW_CFG_SVH
`define HBFW_START_WR 4'hE
`define HBFW_ABORT 4'hF
`define HBFW_TURN 4'hF
`define HBFW_SIZE_ONE 4'h0
`define HBFW_READY_SYNC_OK 4'h0
`define HBFW_BUS_IDLE 4'hF
`define HBFW_CORE_BIT 22
`define HBFW_TOP_BLOCK 4'hF
`define HBFW_ERASE_CMD 8'h30
`define HBFW_ADDR_NIBS 3'h7
`define HBFW_CLK_PS 4000
`define HBFW_SETTLE_NS 1000
`define HBFW_SETTLE_CYC ((`HBFW_SETTLE_NS * 1000 + `HBFW_CLK_PS - 1) / `HBFW_CLK_PS)
`define HBFW_PROG_NS 14000
`define HBFW_PROG_CYC ((`HBFW_PROG_NS * 1000) / `HBFW_CLK_PS)
`define HBFW_ERASE_US 18000
`define HBFW_ERASE_CYC ((`HBFW_ERASE_US * 1000) / (`HBFW_CLK_PS / 1000))
`define HBFW_H_LAST_OUT 5'd13
`define HBFW_H_SYNC 5'd15
`define HBFW_H_END 5'd17
`endif

// ==== hbfw_pkg.sv ====
package hbfw_pkg;
  typedef logic [3:0] hbfw_nib_t;
  typedef enum logic [3:0] {
    HBFW_D_IDLE = 4'h0,
    HBFW_D_ID = 4'h1,
    HBFW_D_ADDR = 4'h3,
    HBFW_D_SIZE = 4'h2,
    HBFW_D_DLO = 4'h6,
    HBFW_D_DHI = 4'h7,
    HBFW_D_TURNAROUND_FIRST = 4'h5,
    HBFW_D_TURNAROUND_SECOND = 4'h4,
    HBFW_D_SYNC = 4'hC,
    HBFW_D_DTAR = 4'h8,
    HBFW_D_WAIT = 4'hF
  } hbfw_dstate_t;
  typedef enum logic [1:0] {
    HBFW_H_IDLE = 2'h0,
    HBFW_H_RUN = 2'h1,
    HBFW_H_ABT = 2'h3
  } hbfw_hstate_t;
endpackage : hbfw_pkg

// ==== hbfw_if.sv ====
`timescale 1ns/1ps
`include "hbfw_cfg.svh"
interface hbfw_if;
  logic frame_strobe_n;
  logic [3:0] host_out;
  logic host_oe;
  logic [3:0] dev_out;
  logic dev_oe;
  logic [3:0] nibble_bus;
  // Pulled-up bus: floating lines read as all ones
  assign nibble_bus = dev_oe ? dev_out :
                      (host_oe ? host_out : `HBFW_BUS_IDLE);
  modport host (output frame_strobe_n, output host_out, output host_oe,
                input nibble_bus);
  modport dev (input frame_strobe_n, output dev_out, output dev_oe,
               input nibble_bus);
endinterface : hbfw_if

// ==== hbfw_host.sv ====
`timescale 1ns/1ps
`include "hbfw_cfg.svh"
module hbfw_host (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  hbfw_if.host bus,
  input wire logic i_req,
  input wire logic i_abort,
  input wire hbfw_pkg::hbfw_nib_t i_id,
  input wire logic [27:0] i_addr,
  input wire logic [7:0] i_data,
  output logic o_ready,
  output logic o_done,
  output logic o_ack_ok
);
  import hbfw_pkg::*;

  // ----------------------------------------
  // Field sequencer
  // ----------------------------------------
  hbfw_hstate_t st_q, st_d;
  logic [4:0] cyc_q, cyc_d;
  logic frame_q, frame_d;
  logic [3:0] out_q, out_d;
  logic oe_q, oe_d;
  logic done_q, done_d;
  logic ready_q, ready_d;
  logic ack_q, ack_d;
  logic [3:0] id_q, id_d;
  logic [27:0] addr_q, addr_d;
  logic [7:0] data_q, data_d;

  function automatic logic [3:0] field(input logic [4:0] c,
                                       input logic [3:0] id,
                                       input logic [27:0] a,
                                       input logic [7:0] d);
    field = `HBFW_TURN;
    case (c)
      5'd1: field = `HBFW_START_WR;
      5'd2: field = id;
      5'd3: field = a[27:24];
      5'd4: field = a[23:20];
      5'd5: field = a[19:16];
      5'd6: field = a[15:12];
      5'd7: field = a[11:8];
      5'd8: field = a[7:4];
      5'd9: field = a[3:0];
      5'd10: field = `HBFW_SIZE_ONE;
      5'd11: field = d[3:0];
      5'd12: field = d[7:4];
      default: field = `HBFW_TURN;
    endcase
  endfunction : field

  always_comb begin
    st_d = st_q;
    cyc_d = cyc_q;
    frame_d = 1'b1;
    out_d = `HBFW_BUS_IDLE;
    oe_d = 1'b0;
    done_d = 1'b0;
    ack_d = ack_q;
    id_d = id_q;
    addr_d = addr_q;
    data_d = data_q;
    case (st_q)
      HBFW_H_IDLE: begin
        if (i_abort) begin
          st_d = HBFW_H_ABT;
          frame_d = 1'b0;
          out_d = `HBFW_ABORT;
          oe_d = 1'b1;
        end else if (i_req) begin
          st_d = HBFW_H_RUN;
          cyc_d = 5'd1;
          frame_d = 1'b0;
          out_d = `HBFW_START_WR;
          oe_d = 1'b1;
          id_d = i_id;
          addr_d = i_addr;
          data_d = i_data;
          ack_d = 1'b0;
        end
      end
      HBFW_H_RUN: begin
        cyc_d = cyc_q + 5'd1;
        // Release after the host turnaround nibble
        oe_d = (cyc_d <= `HBFW_H_LAST_OUT);
        out_d = field(cyc_d, id_q, addr_q, data_q);
        if (cyc_q == `HBFW_H_SYNC)
          ack_d = (bus.nibble_bus == `HBFW_READY_SYNC_OK);
        if (i_abort) begin
          st_d = HBFW_H_ABT;
          frame_d = 1'b0;
          out_d = `HBFW_ABORT;
          oe_d = 1'b1;
        end else if (cyc_q == `HBFW_H_END) begin
          st_d = HBFW_H_IDLE;
          oe_d = 1'b0;
          done_d = 1'b1;
        end
      end
      HBFW_H_ABT: begin
        // Second abort cycle with the strobe high
        st_d = HBFW_H_IDLE;
        out_d = `HBFW_ABORT;
        oe_d = 1'b1;
        done_d = 1'b1;
      end
      default: st_d = HBFW_H_IDLE;
    endcase
    ready_d = (st_d == HBFW_H_IDLE);
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= HBFW_H_IDLE;
      cyc_q <= 5'd0;
      frame_q <= 1'b1;
      out_q <= `HBFW_BUS_IDLE;
      oe_q <= 1'b0;
      done_q <= 1'b0;
      ready_q <= 1'b1;
      ack_q <= 1'b0;
      id_q <= 4'h0;
      addr_q <= 28'h0000000;
      data_q <= 8'h00;
    end else begin
      st_q <= st_d;
      cyc_q <= cyc_d;
      frame_q <= frame_d;
      out_q <= out_d;
      oe_q <= oe_d;
      done_q <= done_d;
      ready_q <= ready_d;
      ack_q <= ack_d;
      id_q <= id_d;
      addr_q <= addr_d;
      data_q <= data_d;
    end
  end

  assign bus.frame_strobe_n = frame_q;
  assign bus.host_out = out_q;
  assign bus.host_oe = oe_q;
  assign o_ready = ready_q;
  assign o_done = done_q;
  assign o_ack_ok = ack_q;
endmodule : hbfw_host

// ==== hbfw_dev.sv ====
`timescale 1ns/1ps
`include "hbfw_cfg.svh"
module hbfw_dev #(
  parameter int unsigned ERASE_CYC = `HBFW_ERASE_CYC
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_init_n,
  hbfw_if.dev bus,
  input wire hbfw_pkg::hbfw_nib_t i_strap_id_pins,
  input wire logic i_top_boot_protect_n,
  input wire logic i_write_protect_n,
  input wire logic [15:0] i_write_lock,
  input wire logic i_status_rd,
  output logic o_busy,
  output logic o_complement_poll_bit,
  output logic o_toggle_status_bit,
  output logic o_byte_valid,
  output logic o_prog_start,
  output logic o_erase_start,
  output logic o_reg_wr,
  output logic [19:0] o_wr_addr,
  output logic [7:0] o_wr_data
);
  import hbfw_pkg::*;

  // ----------------------------------------
  // Reset and pin synchronisers
  // ----------------------------------------
  logic rst_n;
  assign rst_n = i_rst_n & i_init_n;

  logic [21:0] pin_s1_q, pin_s2_q;
  logic [3:0] strap_id;
  logic tbl_n, wp_n;
  logic [15:0] lock;
  assign strap_id = pin_s2_q[3:0];
  assign tbl_n = pin_s2_q[4];
  assign wp_n = pin_s2_q[5];
  assign lock = pin_s2_q[21:6];

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= 22'h000000;
      pin_s2_q <= 22'h000000;
    end else begin
      pin_s1_q <= {i_write_lock, i_write_protect_n, i_top_boot_protect_n,
                   i_strap_id_pins};
      pin_s2_q <= pin_s1_q;
    end
  end

  // Pin low OR lock bit; top 64 KB block has its own pin
  function automatic logic is_protected(input logic [19:0] a,
                                        input logic tbl_pin_n,
                                        input logic wp_pin_n,
                                        input logic [15:0] lk);
    if (a[19:16] == `HBFW_TOP_BLOCK)
      is_protected = !tbl_pin_n | lk[a[19:16]];
    else
      is_protected = !wp_pin_n | lk[a[19:16]];
  endfunction : is_protected

  // ----------------------------------------
  // Bus cycle decoder
  // ----------------------------------------
  hbfw_dstate_t st_q, st_d;
  logic [2:0] cnt_q, cnt_d;
  logic [27:0] addr_q, addr_d;
  logic [7:0] data_q, data_d;
  logic [3:0] dout_q, dout_d;
  logic doe_q, doe_d;
  logic wr_go;
  logic [3:0] nib;
  logic frame_n;
  assign nib = bus.nibble_bus;
  assign frame_n = bus.frame_strobe_n;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    addr_d = addr_q;
    data_d = data_q;
    wr_go = 1'b0;
    case (st_q)
      HBFW_D_IDLE: begin
        if (!frame_n && nib == `HBFW_START_WR)
          st_d = HBFW_D_ID;
      end
      HBFW_D_ID: begin
        // A repeated start keeps the strobe low; the last one counts
        if (!frame_n)
          st_d = (nib == `HBFW_START_WR) ? HBFW_D_ID : HBFW_D_IDLE;
        else if (nib == strap_id) begin
          st_d = HBFW_D_ADDR;
          cnt_d = 3'd0;
        end else
          st_d = HBFW_D_IDLE;
      end
      HBFW_D_ADDR: begin
        addr_d = {addr_q[23:0], nib};
        cnt_d = cnt_q + 3'd1;
        if (cnt_d == `HBFW_ADDR_NIBS)
          st_d = HBFW_D_SIZE;
      end
      HBFW_D_SIZE: begin
        // Bad size: silent drop, bus never driven
        st_d = (nib == `HBFW_SIZE_ONE) ? HBFW_D_DLO : HBFW_D_IDLE;
      end
      HBFW_D_DLO: begin
        data_d = {data_q[7:4], nib};
        st_d = HBFW_D_DHI;
      end
      HBFW_D_DHI: begin
        data_d = {nib, data_q[3:0]};
        st_d = HBFW_D_TURNAROUND_FIRST;
      end
      HBFW_D_TURNAROUND_FIRST: st_d = HBFW_D_TURNAROUND_SECOND;
      HBFW_D_TURNAROUND_SECOND: begin
        st_d = HBFW_D_SYNC;
        wr_go = 1'b1;
      end
      HBFW_D_SYNC: st_d = HBFW_D_DTAR;
      HBFW_D_DTAR: st_d = HBFW_D_IDLE;
      HBFW_D_WAIT: begin
        if (nib == `HBFW_ABORT)
          st_d = HBFW_D_IDLE;
      end
      default: st_d = HBFW_D_IDLE;
    endcase
    // Strobe low in mid-cycle ends it; an abort nibble must follow
    if (frame_n == 1'b0 && st_q != HBFW_D_IDLE && st_q != HBFW_D_ID
        && st_q != HBFW_D_WAIT) begin
      st_d = HBFW_D_WAIT;
      wr_go = 1'b0;
    end
    doe_d = (st_d == HBFW_D_TURNAROUND_SECOND) || (st_d == HBFW_D_SYNC)
            || (st_d == HBFW_D_DTAR);
    dout_d = (st_d == HBFW_D_SYNC) ? `HBFW_READY_SYNC_OK : `HBFW_TURN;
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= HBFW_D_IDLE;
      cnt_q <= 3'd0;
      addr_q <= 28'h0000000;
      data_q <= 8'h00;
      dout_q <= `HBFW_BUS_IDLE;
      doe_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      addr_q <= addr_d;
      data_q <= data_d;
      dout_q <= dout_d;
      doe_q <= doe_d;
    end
  end

  assign bus.dev_out = dout_q;
  assign bus.dev_oe = doe_q;

  // ----------------------------------------
  // Internal program / erase engine
  // ----------------------------------------
  localparam logic [22:0] PROG_CYC = 23'(`HBFW_PROG_CYC);
  localparam logic [22:0] ERASE_LEN = 23'(ERASE_CYC);
  localparam logic [7:0] SETTLE_CYC = 8'(`HBFW_SETTLE_CYC);

  logic busy_q, busy_d;
  logic erase_q, erase_d;
  logic [22:0] op_cnt_q, op_cnt_d;
  logic [7:0] settle_q, settle_d;
  logic [7:0] byte_q, byte_d;
  logic poll_q, poll_d;
  logic tog_q, tog_d;
  logic valid_q, valid_d;
  logic prog_q, prog_d;
  logic ers_q, ers_d;
  logic regw_q, regw_d;
  logic [19:0] waddr_q, waddr_d;
  logic [7:0] wdata_q, wdata_d;
  logic core_hit, is_erase;
  logic [19:0] dec_addr;

  assign dec_addr = addr_q[19:0];
  assign core_hit = addr_q[`HBFW_CORE_BIT];
  assign is_erase = (data_q == `HBFW_ERASE_CMD);

  always_comb begin
    busy_d = busy_q;
    erase_d = erase_q;
    op_cnt_d = op_cnt_q;
    settle_d = settle_q;
    byte_d = byte_q;
    tog_d = tog_q;
    valid_d = valid_q;
    prog_d = 1'b0;
    ers_d = 1'b0;
    regw_d = 1'b0;
    waddr_d = waddr_q;
    wdata_d = wdata_q;
    if (busy_q) begin
      if (i_status_rd)
        tog_d = !tog_q;
      if (op_cnt_q == 23'd0) begin
        busy_d = 1'b0;
        settle_d = SETTLE_CYC;
      end else
        op_cnt_d = op_cnt_q - 23'd1;
    end else if (settle_q != 8'd0) begin
      settle_d = settle_q - 8'd1;
      valid_d = (settle_d == 8'd0);
    end
    // Writes during a running operation are ignored
    if (wr_go && !busy_q) begin
      waddr_d = dec_addr;
      wdata_d = data_q;
      if (!core_hit)
        regw_d = 1'b1;
      else if (!is_protected(dec_addr, tbl_n, wp_n, lock)) begin
        busy_d = 1'b1;
        erase_d = is_erase;
        op_cnt_d = is_erase ? ERASE_LEN : PROG_CYC;
        byte_d = is_erase ? 8'hFF : data_q;
        valid_d = 1'b0;
        settle_d = 8'd0;
        prog_d = !is_erase;
        ers_d = is_erase;
      end
      // Protected core write: sync 0000 still goes out on this edge, nothing starts
    end
    if (busy_d)
      poll_d = erase_d ? 1'b0 : !byte_d[7];
    else
      poll_d = byte_d[7];
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
      erase_q <= 1'b0;
      op_cnt_q <= 23'd0;
      settle_q <= 8'd0;
      byte_q <= 8'hFF;
      poll_q <= 1'b1;
      tog_q <= 1'b0;
      valid_q <= 1'b1;
      prog_q <= 1'b0;
      ers_q <= 1'b0;
      regw_q <= 1'b0;
      waddr_q <= 20'h00000;
      wdata_q <= 8'h00;
    end else begin
      busy_q <= busy_d;
      erase_q <= erase_d;
      op_cnt_q <= op_cnt_d;
      settle_q <= settle_d;
      byte_q <= byte_d;
      poll_q <= poll_d;
      tog_q <= tog_d;
      valid_q <= valid_d;
      prog_q <= prog_d;
      ers_q <= ers_d;
      regw_q <= regw_d;
      waddr_q <= waddr_d;
      wdata_q <= wdata_d;
    end
  end

  assign o_busy = busy_q;
  assign o_complement_poll_bit = poll_q;
  assign o_toggle_status_bit = tog_q;
  assign o_byte_valid = valid_q;
  assign o_prog_start = prog_q;
  assign o_erase_start = ers_q;
  assign o_reg_wr = regw_q;
  assign o_wr_addr = waddr_q;
  assign o_wr_data = wdata_q;
endmodule : hbfw_dev

// ==== hbfw_properties.sv ====
`timescale 1ns/1ps
module hbfw_properties (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_init_n,
  input wire logic frame_strobe_n,
  input wire logic [3:0] host_out,
  input wire logic host_oe,
  input wire logic [3:0] dev_out,
  input wire logic dev_oe,
  input wire logic [3:0] nibble_bus
);
  // ----------------------------------------
  // Bus protocol checks
  // ----------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  // Either reset pin clears the device, so both mask the checks
  default disable iff (!i_rst_n || !i_init_n);

  sequence s_start;
    !frame_strobe_n && nibble_bus == 4'hE ##1 frame_strobe_n;
  endsequence

  AST_START_FIELD: assert property (
    $fell(frame_strobe_n) |-> host_oe && host_out inside {4'hE, 4'hF})
    else $error("strobe fell without start or abort nibble");
  AST_ANSWER_CLOCK: assert property (
    $rose(dev_oe) |-> !$past(frame_strobe_n, 13) &&
      $past(nibble_bus, 13) == 4'hE && $past(frame_strobe_n, 12))
    else $error("device drove bus outside clock 14");
  AST_HOST_LETGO: assert property (
    $rose(dev_oe) |-> !host_oe && $past(host_oe) && $past(host_out) == 4'hF)
    else $error("host turnaround not 1111 before release");
  AST_NO_CONTENTION: assert property (
    dev_oe |-> !host_oe)
    else $error("both ends drive the bus");
  AST_SYNC_READY: assert property (
    $rose(dev_oe) |-> dev_out == 4'hF ##1 dev_oe && dev_out == 4'h0)
    else $error("ready sync not 0000 in clock 15");
  AST_DEV_TAR: assert property (
    $rose(dev_oe) |-> ##2 dev_oe && dev_out == 4'hF ##1 !dev_oe)
    else $error("device turnaround not 1111 then float");
  AST_DEV_SPAN: assert property (
    $rose(dev_oe) |-> dev_oe [*3] ##1 !dev_oe [*2])
    else $error("device drive span not three clocks");
  AST_SIZE_DROP: assert property (
    s_start ##8 (frame_strobe_n && nibble_bus != 4'h0) |-> ##4 !dev_oe [*3])
    else $error("device answered a bad size field");
  AST_ABORT_QUIET: assert property (
    s_start ##[1:11] !frame_strobe_n |-> !dev_oe [*6])
    else $error("device answered a terminated cycle");

  cover property ($rose(dev_oe) ##1 dev_out == 4'h0);
  cover property (s_start ##[1:11] !frame_strobe_n);
  cover property ($fell(frame_strobe_n) && host_out == 4'hF);
endmodule : hbfw_properties

// ==== hub_bus_flash_write_port_tb.sv ====
`timescale 1ns/1ps
module hub_bus_flash_write_port_tb;
  import hbfw_pkg::*;
  logic clk, rst_n, init_n, req, abort, tbp_n, wp_n;
  logic done, ack, busy, poll, bval, ps, es, rw, es2;
  logic rdy, srd, tg, t0;
  hbfw_nib_t id, sid;
  logic [27:0] addr;
  logic [7:0] data, wdata;
  logic [15:0] lock;
  logic [19:0] waddr;
  int fail_count, samples_checked, np, ne, nr, ne2, b;
  hbfw_if b1();
  hbfw_if b2();

  // ----------------------------------------
  // Ends under test
  // ----------------------------------------
  hbfw_host i_hbfw_host (.i_mclk(clk), .i_rst_n(rst_n), .bus(b1.host),
    .i_req(req), .i_abort(abort), .i_id(id), .i_addr(addr), .i_data(data),
    .o_ready(rdy), .o_done(done), .o_ack_ok(ack));
  hbfw_dev #(.ERASE_CYC(20)) i_hbfw_dev (.i_mclk(clk), .i_rst_n(rst_n),
    .i_init_n(init_n), .bus(b1.dev), .i_strap_id_pins(sid),
    .i_top_boot_protect_n(tbp_n), .i_write_protect_n(wp_n),
    .i_write_lock(lock), .i_status_rd(srd), .o_busy(busy),
    .o_complement_poll_bit(poll), .o_toggle_status_bit(tg),
    .o_byte_valid(bval), .o_prog_start(ps), .o_erase_start(es),
    .o_reg_wr(rw), .o_wr_addr(waddr), .o_wr_data(wdata));
  // Second device faces the bench directly, so bad hosts can be mimicked
  hbfw_dev #(.ERASE_CYC(20)) i_hbfw_dev_b (.i_mclk(clk), .i_rst_n(rst_n),
    .i_init_n(init_n), .bus(b2.dev), .i_strap_id_pins(sid),
    .i_top_boot_protect_n(tbp_n), .i_write_protect_n(wp_n),
    .i_write_lock(lock), .i_status_rd(1'b0), .o_busy(),
    .o_complement_poll_bit(), .o_toggle_status_bit(), .o_byte_valid(),
    .o_prog_start(), .o_erase_start(es2), .o_reg_wr(), .o_wr_addr(),
    .o_wr_data());
  hbfw_properties i_hbfw_properties (.i_mclk(clk), .i_rst_n(rst_n),
    .i_init_n(init_n), .frame_strobe_n(b1.frame_strobe_n),
    .host_out(b1.host_out), .host_oe(b1.host_oe), .dev_out(b1.dev_out),
    .dev_oe(b1.dev_oe), .nibble_bus(b1.nibble_bus));

  always @(posedge clk) begin
    if (ps === 1'b1) np++;
    if (es === 1'b1) ne++;
    if (rw === 1'b1) nr++;
    if (es2 === 1'b1) ne2++;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %0h seen %0h", n, e, g);
    end
  endtask : chk

  task wr(input hbfw_nib_t i, input logic [27:0] a, input logic [7:0] d,
          input logic abt);
    int k;
    id = i;
    addr = a;
    data = d;
    req = 1'b1;
    @(negedge clk);
    req = 1'b0;
    if (abt) begin
      repeat (4) @(negedge clk);
      abort = 1'b1;
      @(negedge clk);
      abort = 1'b0;
    end
    k = 0;
    while (done !== 1'b1 && k < 60) begin
      @(negedge clk);
      k++;
    end
    chk("done", 1, done);
    chk("ready", 1, rdy);
  endtask : wr

  task wait_idle(input int lim);
    int k;
    k = 0;
    while (busy === 1'b1 && k < lim) begin
      @(negedge clk);
      k++;
    end
    chk("busy", 0, busy);
  endtask : wait_idle

  task drv(input logic [3:0] n, input logic f);
    b2.frame_strobe_n = f;
    b2.host_out = n;
    b2.host_oe = 1'b1;
    @(negedge clk);
  endtask : drv

  task complete_run;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_prog;
    b = np;
    wr(sid, 28'hAF4A5C3, 8'hB6, 1'b0);
    chk("ack", 1, ack);
    chk("prog", b + 1, np);
    chk("addr", 20'h4A5C3, waddr);
    chk("data", 8'hB6, wdata);
    chk("poll", 0, poll);
    wait_idle(4000);
    chk("poll", 1, poll);
    // Two more status reads before completion is trusted
    repeat (2) begin
      @(negedge clk);
      chk("poll", 1, poll);
    end
    repeat (240) @(negedge clk);
    chk("valid", 0, bval);
    repeat (20) @(negedge clk);
    chk("valid", 1, bval);
    $display("program test ended");
  endtask : t_prog

  task t_erase;
    b = ne;
    wr(sid, 28'h0430000, 8'h30, 1'b0);
    chk("erase", b + 1, ne);
    chk("poll", 0, poll);
    t0 = tg;
    srd = 1'b1;
    @(negedge clk);
    srd = 1'b0;
    chk("toggle", !t0, tg);
    wait_idle(100);
    chk("poll", 1, poll);
    t0 = tg;
    srd = 1'b1;
    @(negedge clk);
    srd = 1'b0;
    chk("toggle", t0, tg);
    $display("erase test ended");
  endtask : t_erase

  task t_prot;
    logic [7:0] tv [5];
    logic [7:0] c;
    int i;
    // Packed as boot pin, wp pin, lock, expect, block
    tv = '{8'h4F, 8'h9F, 8'h82, 8'hE2, 8'h52};
    for (i = 0; i < 5; i++) begin
      c = tv[i];
      tbp_n = c[7];
      wp_n = c[6];
      lock = c[5] ? 16'h1 << c[3:0] : 16'h0;
      // Pins pass two sync flops before they count
      repeat (3) @(negedge clk);
      b = ne;
      wr(sid, {8'h04, c[3:0], 16'h0000}, 8'h30, 1'b0);
      chk("ack", 1, ack);
      chk("erase", b + c[4], ne);
      wait_idle(100);
    end
    tbp_n = 1'b1;
    wp_n = 1'b1;
    lock = 16'h0;
    $display("protect test ended");
  endtask : t_prot

  task t_id_abort;
    b = np + ne + nr;
    wr(sid ^ 4'h1, 28'h0412345, 8'h11, 1'b0);
    chk("ack", 0, ack);
    wr(sid, 28'h0412345, 8'h22, 1'b1);
    chk("count", b, np + ne + nr);
    wr(sid, 28'h0012345, 8'h05, 1'b0);
    chk("ack", 1, ack);
    chk("reg", b + 1, np + ne + nr);
    chk("addr", 20'h12345, waddr);
    $display("id and abort test ended");
  endtask : t_id_abort

  task t_reset;
    int k;
    wr(sid, 28'h0450000, 8'h30, 1'b0);
    chk("busy", 1, busy);
    init_n = 1'b0;
    @(negedge clk);
    chk("busy", 0, busy);
    chk("poll", 1, poll);
    init_n = 1'b1;
    repeat (3) @(negedge clk);
    req = 1'b1;
    @(negedge clk);
    req = 1'b0;
    k = 0;
    while (b1.dev_oe !== 1'b1 && k < 20) begin
      @(negedge clk);
      k++;
    end
    chk("dev_oe", 1, b1.dev_oe);
    rst_n = 1'b0;
    #1;
    chk("dev_oe", 0, b1.dev_oe);
    @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    $display("reset test ended");
  endtask : t_reset

  task t_size;
    int s, i;
    logic [27:0] a;
    a = 28'h0460000;
    for (s = 0; s < 2; s++) begin
      b = ne2;
      drv(4'hE, 1'b0);
      drv(4'hE, 1'b0);
      drv(sid, 1'b1);
      for (i = 6; i >= 0; i--) drv(a[i*4+:4], 1'b1);
      drv(4'(s), 1'b1);
      drv(4'h0, 1'b1);
      drv(4'h3, 1'b1);
      drv(4'hF, 1'b1);
      b2.host_oe = 1'b0;
      @(negedge clk);
      chk("sync", s ? 4'hF : 4'h0, b2.nibble_bus);
      repeat (4) @(negedge clk);
      chk("erase", b + 1 - s, ne2);
      repeat (30) @(negedge clk);
    end
    $display("size test ended");
  endtask : t_size

  // ----------------------------------------
  // Run control
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    complete_run();
  end

  initial begin
    {rst_n, req, abort, srd, lock, addr, data} = '0;
    {init_n, tbp_n, wp_n} = 3'b111;
    sid = 4'h5;
    id = 4'h5;
    b2.frame_strobe_n = 1'b1;
    b2.host_out = 4'hF;
    b2.host_oe = 1'b0;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_prog();
    t_erase();
    t_prot();
    t_id_abort();
    t_reset();
    t_size();
    complete_run();
  end
endmodule : hub_bus_flash_write_port_tb
